// *** rtc_host_model.sv ***
// Host processor model that reaches the block through the index and data ports.
`timescale 1ns/1ps
module rtc_host_model (
  input  wire logic       mclk,
  output logic            host_wr,
  output logic            host_rd,
  output logic            host_sel_data,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata
);
  // ---------------------------------------------------------------------------
  // Port cycles, launched and released at falling edges
  // ---------------------------------------------------------------------------
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_sel_data = 1'b0;
    host_wdata = 8'h00;
  end
  // Write strobe across one rising edge; released data shows the inverse.
  task automatic put(input logic sel, input logic [7:0] d);
    @(negedge mclk);
    host_wr = 1'b1;
    host_sel_data = sel;
    host_wdata = d;
    @(negedge mclk);
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  // Read strobe across one rising edge; the byte is taken at release.
  task automatic get(input logic sel, output logic [7:0] d);
    @(negedge mclk);
    host_rd = 1'b1;
    host_sel_data = sel;
    @(negedge mclk);
    host_rd = 1'b0;
    d = host_rdata;
  endtask
  // Index first, then the data port.
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    put(1'b0, idx);
    put(1'b1, d);
  endtask
  // Read-modify-write that leaves the other bits as they were.
  task automatic rmw(input logic [7:0] idx, input logic [7:0] keep, input logic [7:0] set);
    logic [7:0] v;
    put(1'b0, idx);
    get(1'b1, v);
    wr_reg(idx, (v & keep) | set);
  endtask
endmodule

// *** rtc_pkg.sv ***
// Constants shared by the cursor and vertical timing block of the raster timing controller.
package rtc_pkg;
  // ---------------------------------------------------------------------------
  // Register indexes behind the data port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_OVERFLOW  = 8'h07;
  localparam logic [7:0] IDX_CUR_START = 8'h0A;
  localparam logic [7:0] IDX_CUR_END   = 8'h0B;
  localparam logic [7:0] IDX_SA_HIGH   = 8'h0C;
  localparam logic [7:0] IDX_SA_LOW    = 8'h0D;
  localparam logic [7:0] IDX_CL_HIGH   = 8'h0E;
  localparam logic [7:0] IDX_CL_LOW    = 8'h0F;
  localparam logic [7:0] IDX_VRS_LOW   = 8'h10;
  localparam logic [7:0] IDX_VRE_CTRL  = 8'h11;
  localparam logic [7:0] IDX_VDE_LOW   = 8'h12;
  localparam logic [7:0] IDX_ROW_PITCH = 8'h13;
  localparam logic [7:0] IDX_LOCK_LAST = 8'h07;
  // ---------------------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------------------
  localparam int         CS_OFF_BIT    = 5;
  localparam int         CE_SKEW_LSB   = 5;
  localparam int         VRE_LOCK_BIT  = 7;
  localparam int         VRE_REF5_BIT  = 6;
  localparam int         VRE_IEN_N_BIT = 5;
  localparam int         VRE_ICLR_N_BIT = 4;
  localparam int         OVF_VRS9_BIT  = 7;
  localparam int         OVF_VDE9_BIT  = 6;
  localparam int         OVF_LC8_BIT   = 4;
  localparam int         OVF_VRS8_BIT  = 2;
  localparam int         OVF_VDE8_BIT  = 1;
  localparam logic [7:0] CS_MASK       = 8'h3F;
  localparam logic [7:0] CE_MASK       = 8'h7F;
  localparam logic [7:0] LC8_MASK      = 8'h10;
  // ---------------------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam logic [15:0] ADDR_RST     = 16'h0000;
  localparam logic [9:0]  LINE_RST     = 10'h000;
  localparam logic [4:0]  ROW_RST      = 5'h00;
  localparam logic [2:0]  REFRESH_FIVE = 3'h5;
  localparam logic [2:0]  REFRESH_THREE = 3'h3;
  localparam int          SKEW_DEPTH   = 3;
endpackage

// *** rtc_vtiming.sv ***
// Cursor, start address and vertical retrace logic of the raster timing controller.
// Overview of operation
// RL1: Index register selects, data port accesses registers.
// RL2: Cursor off bit suppresses the cursor.
// RL3: Cursor start row scan, five bits.
// RL4: Start above end gives no cursor.
// RL5: Cursor end row scan, five bits.
// RL6: Skew delays cursor zero to three clocks.
// RL7: Start address loads counter at vertical retrace start.
// RL8: Two registers form sixteen-bit cursor address.
// RL9: Cursor when address matches and row within.
// RL10: Retrace start low byte plus overflow bit.
// RL11: Overflow bit seven is retrace start bit nine.
// RL12: Retrace ends when line low nibble matches.
// RL13: Lock bit blocks writes to indexes zero-seven.
// RL14: Line compare overflow bit stays writable.
// RL15: Refresh select picks five or three cycles.
// RL16: Active-low bit enables vertical interrupt.
// RL17: End of active display sets interrupt flop.
// RL18: Clear bit low holds interrupt flop cleared.
// RL19: Software read-modify-writes the retrace end register.
// RL20: Display end is ten bits via overflow.
// RL21: Next row starts pitch times two or four.
// RL22: Row scan advances per line, clears at max.
// RL23: Reserved cursor bits ignored, read as zero.
`timescale 1ns/1ps
module rtc_vtiming (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic        host_sel_data,
  input  wire logic [7:0]  host_wdata,
  input  wire logic        char_en,
  input  wire logic        hscan_en,
  input  wire logic        frame_start,
  input  wire logic        h_active,
  input  wire logic        dword_mode,
  input  wire logic [4:0]  max_scan_line,
  output logic [7:0]       host_rdata,
  output logic [15:0]      mem_addr,
  output logic             cursor,
  output logic             vretrace,
  output logic             shared_video_irq_line,
  output logic             timing_write_lock,
  output logic [2:0]       refresh_cycles
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  idx;
    logic [7:0]  ovf;
    logic [7:0]  cs;
    logic [7:0]  ce;
    logic [7:0]  sah;
    logic [7:0]  sal;
    logic [7:0]  clh;
    logic [7:0]  cll;
    logic [7:0]  vrs;
    logic [7:0]  vre;
    logic [7:0]  vde;
    logic [7:0]  pitch;
    logic [9:0]  line;
    logic [4:0]  row;
    logic [15:0] row_start;
    logic [15:0] ma;
    logic [2:0]  skew;
    logic        vret;
    logic        irq;
    logic        cursor;
    logic [7:0]  rdata;
    logic [2:0]  refresh;
  } rtc_state_t;

  rtc_state_t s_q;
  rtc_state_t s_d;
  logic [9:0] vrs_full;
  logic [9:0] vde_full;
  logic [9:0] line_next;
  logic [15:0] cur_addr;
  logic [15:0] start_addr;
  logic [15:0] step;
  logic       data_wr;
  logic       locked;
  logic       cur_raw;
  logic [1:0] skew_sel;

  // Ten-bit compare values and sixteen-bit addresses assembled from their pieces.
  assign vrs_full   = {s_q.ovf[rtc_pkg::OVF_VRS9_BIT], s_q.ovf[rtc_pkg::OVF_VRS8_BIT],
                       s_q.vrs};  // see RL10 see RL11
  assign vde_full   = {s_q.ovf[rtc_pkg::OVF_VDE9_BIT], s_q.ovf[rtc_pkg::OVF_VDE8_BIT],
                       s_q.vde};  // see RL20
  assign cur_addr   = {s_q.clh, s_q.cll};  // see RL8
  assign start_addr = {s_q.sah, s_q.sal};
  assign line_next  = frame_start ? rtc_pkg::LINE_RST : s_q.line + 10'h001;
  assign step       = dword_mode ? {6'h00, s_q.pitch, 2'h0}
                                 : {7'h00, s_q.pitch, 1'h0};  // see RL21
  assign data_wr    = host_wr & host_sel_data;  // see RL1
  assign locked     = s_q.vre[rtc_pkg::VRE_LOCK_BIT] & (s_q.idx <= rtc_pkg::IDX_LOCK_LAST);
  assign skew_sel   = s_q.ce[rtc_pkg::CE_SKEW_LSB +: 2];

  // Undelayed cursor: address match, row inside the window, enabled and well ordered.
  assign cur_raw = h_active && (s_q.ma == cur_addr)                          // see RL9
                   && !s_q.cs[rtc_pkg::CS_OFF_BIT]                           // see RL2
                   && (s_q.cs[4:0] <= s_q.ce[4:0])                           // see RL4
                   && (s_q.row >= s_q.cs[4:0]) && (s_q.row <= s_q.ce[4:0]);  // see RL3 see RL5

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Register writes, raster counters, retrace, interrupt and cursor pipeline.
  always_comb begin
    s_d = s_q;
    if (host_wr && !host_sel_data) begin
      s_d.idx = host_wdata;
    end
    if (data_wr) begin
      case (s_q.idx)
        rtc_pkg::IDX_OVERFLOW: begin
          if (locked) begin
            s_d.ovf = (s_q.ovf & ~rtc_pkg::LC8_MASK)
                      | (host_wdata & rtc_pkg::LC8_MASK);  // see RL13 see RL14
          end else begin
            s_d.ovf = host_wdata;
          end
        end
        rtc_pkg::IDX_CUR_START: s_d.cs    = host_wdata & rtc_pkg::CS_MASK;  // see RL23
        rtc_pkg::IDX_CUR_END:   s_d.ce    = host_wdata & rtc_pkg::CE_MASK;  // see RL23
        rtc_pkg::IDX_SA_HIGH:   s_d.sah   = host_wdata;
        rtc_pkg::IDX_SA_LOW:    s_d.sal   = host_wdata;
        rtc_pkg::IDX_CL_HIGH:   s_d.clh   = host_wdata;
        rtc_pkg::IDX_CL_LOW:    s_d.cll   = host_wdata;
        rtc_pkg::IDX_VRS_LOW:   s_d.vrs   = host_wdata;
        rtc_pkg::IDX_VRE_CTRL:  s_d.vre   = host_wdata;
        rtc_pkg::IDX_VDE_LOW:   s_d.vde   = host_wdata;
        rtc_pkg::IDX_ROW_PITCH: s_d.pitch = host_wdata;
        default: begin
        end
      endcase
    end
    // Read data is captured on the same rising edge that samples the read strobe.
    if (host_rd) begin
      if (!host_sel_data) begin
        s_d.rdata = s_q.idx;
      end else begin
        case (s_q.idx)
          rtc_pkg::IDX_OVERFLOW:  s_d.rdata = s_q.ovf;
          rtc_pkg::IDX_CUR_START: s_d.rdata = s_q.cs;
          rtc_pkg::IDX_CUR_END:   s_d.rdata = s_q.ce;
          rtc_pkg::IDX_SA_HIGH:   s_d.rdata = s_q.sah;
          rtc_pkg::IDX_SA_LOW:    s_d.rdata = s_q.sal;
          rtc_pkg::IDX_CL_HIGH:   s_d.rdata = s_q.clh;
          rtc_pkg::IDX_CL_LOW:    s_d.rdata = s_q.cll;
          rtc_pkg::IDX_VRS_LOW:   s_d.rdata = s_q.vrs;
          rtc_pkg::IDX_VRE_CTRL:  s_d.rdata = s_q.vre;  // see RL19
          rtc_pkg::IDX_VDE_LOW:   s_d.rdata = s_q.vde;
          rtc_pkg::IDX_ROW_PITCH: s_d.rdata = s_q.pitch;
          default:                s_d.rdata = rtc_pkg::REG_RST;
        endcase
      end
    end
    // The address counter steps once per character while the line is active.
    if (char_en && h_active) begin
      s_d.ma = s_q.ma + 16'h0001;
    end
    // Per scan line: line count, row scan, row start, retrace and interrupt.
    if (hscan_en) begin
      s_d.line = line_next;
      if (s_q.row == max_scan_line) begin
        s_d.row       = rtc_pkg::ROW_RST;  // see RL22
        s_d.row_start = s_q.row_start + step;  // see RL21
        s_d.ma        = s_q.row_start + step;
      end else begin
        s_d.row = s_q.row + 5'h01;  // see RL22
        s_d.ma  = s_q.row_start;
      end
      if (s_q.vret && (line_next[3:0] == s_q.vre[3:0])) begin
        s_d.vret = 1'b0;  // see RL12
      end
      if (line_next == vrs_full) begin
        s_d.vret      = 1'b1;  // see RL10
        s_d.row       = rtc_pkg::ROW_RST;
        s_d.row_start = start_addr;  // see RL7
        s_d.ma        = start_addr;  // see RL7
      end
      if ((s_q.line == vde_full) && !s_q.vre[rtc_pkg::VRE_IEN_N_BIT]) begin
        s_d.irq = 1'b1;  // see RL16 see RL17
      end
    end
    // A low clear bit holds the flop cleared and overrides any new event.
    if (!s_q.vre[rtc_pkg::VRE_ICLR_N_BIT]) begin
      s_d.irq = 1'b0;  // see RL18
    end
    // Skew line shifts once per character clock.
    if (char_en) begin
      s_d.skew = {s_q.skew[1:0], cur_raw};  // see RL6
    end
    case (skew_sel)
      2'h0:    s_d.cursor = cur_raw;  // see RL6
      2'h1:    s_d.cursor = s_q.skew[0];
      2'h2:    s_d.cursor = s_q.skew[1];
      default: s_d.cursor = s_q.skew[2];
    endcase
    s_d.refresh = s_q.vre[rtc_pkg::VRE_REF5_BIT] ? rtc_pkg::REFRESH_FIVE
                                                 : rtc_pkg::REFRESH_THREE;  // see RL15
  end

  // State register, all fields cleared by reset except refresh, which loads three.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.refresh <= rtc_pkg::REFRESH_THREE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign host_rdata            = s_q.rdata;
  assign mem_addr              = s_q.ma;
  assign cursor                = s_q.cursor;
  assign vretrace              = s_q.vret;
  assign shared_video_irq_line = s_q.irq;
  assign timing_write_lock     = s_q.vre[rtc_pkg::VRE_LOCK_BIT];  // see RL13
  assign refresh_cycles        = s_q.refresh;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence data_write_s(logic [7:0] i);
    host_wr && host_sel_data && s_q.idx == i;
  endsequence

  lock_overflow_a: assert property (  // see RL13
    data_write_s(rtc_pkg::IDX_OVERFLOW) ##0 s_q.vre[7]
    |=> (s_q.ovf & 8'hEF) == ($past(s_q.ovf) & 8'hEF))
    else $error("Locked overflow write changed protected bits.");
  lc_bit_write_a: assert property (  // see RL14
    data_write_s(rtc_pkg::IDX_OVERFLOW) |=> s_q.ovf[4] == $past(host_wdata[4]))
    else $error("Line compare bit not written.");
  cs_reserved_a: assert property (  // see RL23
    data_write_s(rtc_pkg::IDX_CUR_START) |=> s_q.cs[7:6] == 2'h0)
    else $error("Reserved cursor start bits stored.");
  irq_hold_a: assert property (  // see RL18
    !s_q.vre[4] |=> !s_q.irq)
    else $error("Interrupt flop set while clear bit low.");
  irq_set_a: assert property (  // see RL17
    hscan_en && s_q.line == vde_full && !s_q.vre[5] && s_q.vre[4] |=> s_q.irq)
    else $error("Interrupt not set at display end.");
  irq_mask_a: assert property (  // see RL16
    s_q.vre[5] && !s_q.irq |=> !s_q.irq)
    else $error("Disabled interrupt was raised.");
  vret_start_a: assert property (  // see RL7
    hscan_en && line_next == vrs_full |=> s_q.vret && s_q.ma == $past(start_addr))
    else $error("Retrace start did not load start address.");
  vret_end_a: assert property (  // see RL12
    hscan_en && s_q.vret && line_next[3:0] == s_q.vre[3:0] && line_next != vrs_full
    |=> !s_q.vret)
    else $error("Retrace did not end on matching line.");
  cursor_off_a: assert property (  // see RL2
    s_q.cs[5] && s_q.ce[6:5] == 2'h0 |=> !s_q.cursor)
    else $error("Cursor shown while disabled.");
  refresh_sel_a: assert property (  // see RL15
    ##1 refresh_cycles == ($past(s_q.vre[6]) ? 3'h5 : 3'h3))
    else $error("Refresh count does not follow select bit.");

  // Index register and raster counter checks.
  index_write_a: assert property (  // see RL1
    host_wr && !host_sel_data |=> s_q.idx == $past(host_wdata))
    else $error("Index register did not take the written byte.");
  rdata_idx_a: assert property (  // see RL1
    host_rd && !host_sel_data |=> host_rdata == $past(s_q.idx))
    else $error("Index read did not return the index.");
  ma_step_a: assert property (  // see RL9
    char_en && h_active && !hscan_en |=> s_q.ma == $past(s_q.ma) + 16'h0001)
    else $error("Address counter did not step on a character.");
  row_advance_a: assert property (  // see RL22
    hscan_en && s_q.row != max_scan_line && line_next != vrs_full
    |=> s_q.row == $past(s_q.row) + 5'h01)
    else $error("Row scan did not advance at line end.");
  row_wrap_a: assert property (  // see RL21
    hscan_en && s_q.row == max_scan_line && line_next != vrs_full
    |=> s_q.row == rtc_pkg::ROW_RST && s_q.row_start == $past(s_q.row_start) + $past(step))
    else $error("Row start did not step by the pitch.");

  // Cursor pipeline checks.
  sequence skew_load_s;
    char_en && cur_raw;
  endsequence
  skew_one_a: assert property (  // see RL6
    skew_load_s ##1 skew_sel == 2'h1 |=> s_q.cursor)
    else $error("Cursor not delayed by one character.");
  order_none_a: assert property (  // see RL4
    s_q.cs[4:0] > s_q.ce[4:0] && skew_sel == 2'h0 |=> !s_q.cursor)
    else $error("Cursor shown with start above end.");
  row_window_a: assert property (  // see RL5
    (s_q.row < s_q.cs[4:0] || s_q.row > s_q.ce[4:0]) && skew_sel == 2'h0 |=> !s_q.cursor)
    else $error("Cursor shown outside its row window.");

endmodule

// *** tb_top.sv ***
// Self-checking testbench of the cursor and vertical timing block.
`timescale 1ns/1ps
module tb_top;
  logic        mclk, rst_b, host_wr, host_rd, host_sel_data, rd_d;
  logic        char_en, hscan_en, frame_start, h_active, dword_mode;
  logic        cursor, vretrace, shared_video_irq_line, timing_write_lock;
  logic [2:0]  refresh_cycles;
  logic [4:0]  max_scan_line, rw;
  logic [7:0]  host_wdata, host_rdata, pitch, v;
  logic [15:0] mem_addr, sa, ca;
  logic [7:0]  exp_q[$];
  int          errors;
  int          compares;
  // ---------------------------------------------------------------------------
  // Design, host model and clock
  // ---------------------------------------------------------------------------
  rtc_vtiming dut (.mclk(mclk), .rst_b(rst_b), .host_wr(host_wr), .host_rd(host_rd),
    .host_sel_data(host_sel_data), .host_wdata(host_wdata), .char_en(char_en),
    .hscan_en(hscan_en), .frame_start(frame_start), .h_active(h_active),
    .dword_mode(dword_mode), .max_scan_line(max_scan_line), .host_rdata(host_rdata),
    .mem_addr(mem_addr), .cursor(cursor), .vretrace(vretrace),
    .shared_video_irq_line(shared_video_irq_line), .timing_write_lock(timing_write_lock),
    .refresh_cycles(refresh_cycles));
  rtc_host_model host (.mclk(mclk), .host_wr(host_wr), .host_rd(host_rd),
    .host_sel_data(host_sel_data), .host_wdata(host_wdata), .host_rdata(host_rdata));
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  // Compares one result and counts it.
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Each read made while an expectation is queued is matched against the oldest one.
  always @(posedge mclk) begin
    if (rd_d && exp_q.size() > 0) begin
      check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, host_rdata});
    end
    rd_d <= host_rd;
  end
  // Notes the expected byte, then reads the register.
  task automatic rd_exp(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    host.put(1'b0, idx);
    host.get(1'b1, v);
  endtask
  // One end-of-line pulse; the row tracker follows it.
  task automatic hs(input logic fs);
    @(negedge mclk);
    hscan_en = 1'b1;
    frame_start = fs;
    @(negedge mclk);
    hscan_en = 1'b0;
    frame_start = 1'b0;
    rw = rw + 5'h01;
  endtask
  // Eight characters across the line; notes where the cursor shows and how wide.
  task automatic cur(input logic off, input logic [1:0] skew, input logic [4:0] cs_d,
                     input logic [4:0] ce_d, input logic [15:0] first);
    logic [15:0] hit;
    logic [15:0] at;
    logic [4:0]  r;
    r = rw + 5'h01;
    hit = 16'h0000;
    at = 16'h0000;
    host.wr_reg(rtc_pkg::IDX_CUR_START, {2'b00, off, r + cs_d});
    host.wr_reg(rtc_pkg::IDX_CUR_END, {1'b0, skew, r + ce_d});
    hs(1'b0);
    h_active = 1'b1;
    for (int i = 1; i < 9; i++) begin
      char_en = 1'b1;
      @(negedge mclk);
      char_en = 1'b0;
      @(negedge mclk);
      if (cursor === 1'b1) begin
        hit = hit + 16'h0001;
        at = 16'(i);
      end
    end
    h_active = 1'b0;
    check("cursor at", first, at);
    check("cursor width", (first != 16'h0000) ? 16'h0001 : 16'h0000, hit);
  endtask
  // Run limit that cuts a hang short.
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    stop_test();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst_b, char_en, hscan_en, frame_start, h_active, dword_mode} = 6'h00;
    max_scan_line = 5'h1F;
    rw = 5'h00;
    v = 8'($urandom(58070));
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    check("refresh", 16'h0003, {13'h0000, refresh_cycles});
    rst_b = 1'b1;
    for (int i = 8'h0A; i < 8'h14; i++) rd_exp(8'(i), 8'h00);
    for (int i = 8'h0A; i < 8'h14; i++) begin
      v = 8'($urandom());
      host.wr_reg(8'(i), v);
      rd_exp(8'(i), (i == 10) ? (v & 8'h3F) : (i == 11) ? (v & 8'h7F) : v);
    end
    rd_exp(8'h20, 8'h00);
    exp_q.push_back(8'h20);
    host.get(1'b0, v);
    host.wr_reg(rtc_pkg::IDX_VRE_CTRL, 8'h00);
    host.wr_reg(rtc_pkg::IDX_OVERFLOW, 8'h00);
    host.wr_reg(rtc_pkg::IDX_VRE_CTRL, 8'h80);
    check("lock", 16'h0001, {15'h0000, timing_write_lock});
    host.wr_reg(rtc_pkg::IDX_OVERFLOW, 8'hFF);
    rd_exp(rtc_pkg::IDX_OVERFLOW, 8'h10);
    host.wr_reg(rtc_pkg::IDX_VRE_CTRL, 8'h00);
    host.wr_reg(rtc_pkg::IDX_OVERFLOW, 8'h80);
    rd_exp(rtc_pkg::IDX_OVERFLOW, 8'h80);
    sa = 16'($urandom());
    ca = sa + 16'h0002;
    pitch = 8'($urandom());
    host.wr_reg(rtc_pkg::IDX_SA_HIGH, sa[15:8]);
    host.wr_reg(rtc_pkg::IDX_SA_LOW, sa[7:0]);
    host.wr_reg(rtc_pkg::IDX_CL_HIGH, ca[15:8]);
    host.wr_reg(rtc_pkg::IDX_CL_LOW, ca[7:0]);
    host.wr_reg(rtc_pkg::IDX_ROW_PITCH, pitch);
    host.wr_reg(rtc_pkg::IDX_VRS_LOW, 8'h05);
    host.wr_reg(rtc_pkg::IDX_VDE_LOW, 8'h10);
    host.wr_reg(rtc_pkg::IDX_VRE_CTRL, 8'h58);
    @(negedge mclk);
    check("refresh", 16'h0005, {13'h0000, refresh_cycles});
    hs(1'b1);
    repeat (15) hs(1'b0);
    check("irq", 16'h0000, {15'h0000, shared_video_irq_line});
    repeat (2) hs(1'b0);
    check("irq", 16'h0001, {15'h0000, shared_video_irq_line});
    host.rmw(rtc_pkg::IDX_VRE_CTRL, 8'hEF, 8'h00);
    host.rmw(rtc_pkg::IDX_VRE_CTRL, 8'hFF, 8'h10);
    check("irq", 16'h0000, {15'h0000, shared_video_irq_line});
    repeat (16'h01F3) hs(1'b0);
    check("vretrace", 16'h0000, {15'h0000, vretrace});
    hs(1'b0);
    rw = 5'h00;
    check("vretrace", 16'h0001, {15'h0000, vretrace});
    check("mem_addr", sa, mem_addr);
    repeat (2) hs(1'b0);
    check("vretrace", 16'h0001, {15'h0000, vretrace});
    hs(1'b0);
    check("vretrace", 16'h0000, {15'h0000, vretrace});
    for (int k = 0; k < 4; k++) cur(1'b0, 2'(k), 5'h00, 5'h00, 16'(k + 2));
    cur(1'b1, 2'b00, 5'h00, 5'h00, 16'h0000);
    cur(1'b0, 2'b00, 5'h01, 5'h00, 16'h0000);
    cur(1'b0, 2'b00, 5'h01, 5'h02, 16'h0000);
    cur(1'b0, 2'b00, 5'h1F, 5'h1F, 16'h0000);
    cur(1'b0, 2'b01, 5'h1F, 5'h01, 16'h0003);
    max_scan_line = rw;
    hs(1'b0);
    max_scan_line = 5'h1F;
    hs(1'b0);
    check("mem_addr", sa + {8'h00, pitch} * 16'h0002, mem_addr);
    dword_mode = 1'b1;
    max_scan_line = 5'h01;
    hs(1'b0);
    max_scan_line = 5'h1F;
    hs(1'b0);
    check("mem_addr", sa + {8'h00, pitch} * 16'h0006, mem_addr);
    host.wr_reg(rtc_pkg::IDX_VRE_CTRL, 8'h78);
    hs(1'b1);
    repeat (17) hs(1'b0);
    check("irq", 16'h0000, {15'h0000, shared_video_irq_line});
    host.wr_reg(rtc_pkg::IDX_VRE_CTRL, 8'h48);
    hs(1'b1);
    repeat (17) hs(1'b0);
    check("irq", 16'h0000, {15'h0000, shared_video_irq_line});
    stop_test();
  end
endmodule
